// ===== src/mcsr_pkg.sv
/*
 * Constants for the transmit/receive security capability and control
 * register bank: offsets, field positions, reset values, mode codes.
 * Assumes a 16-bit byte address and 32-bit register words.
 */
package mcsr_pkg;

	// ==========================================================
	// Bus geometry
	localparam int ADDR_W = 16;
	localparam int DATA_W = 32;

	// ==========================================================
	// Register offsets (byte addresses)
	localparam logic [15:0] TX_CAP_OFS   = 16'hb000;
	localparam logic [15:0] TX_CTRL_OFS  = 16'hb004;
	localparam logic [15:0] TX_SA_OFS    = 16'hb010;
	localparam logic [15:0] TX_PN0_OFS   = 16'hb018;
	localparam logic [15:0] TX_PN1_OFS   = 16'hb01c;
	localparam logic [15:0] TX_KEY_OFS   = 16'hb020;
	localparam logic [15:0] IRQ_STAT_OFS = 16'hb040;
	localparam logic [15:0] IRQ_MASK_OFS = 16'hb044;
	localparam logic [15:0] RX_CAP_OFS   = 16'hb300;
	localparam logic [15:0] RX_KEY_OFS   = 16'hb320;

	// ==========================================================
	// Capability fields
	localparam int         CA_LSB     = 0;
	localparam int         SC_LSB     = 3;
	localparam int         SUM_LSB    = 16;
	localparam logic [2:0] TX_CA_NUM  = 3'h1;
	localparam logic [3:0] TX_SC_NUM  = 4'h1;
	localparam logic [2:0] RX_CA_NUM  = 3'h1;
	localparam int         KEY_WORDS  = 4;
	localparam int         TX_KEYS    = 2;

	// ==========================================================
	// Transmit control fields
	localparam int          MODE_LSB  = 0;
	localparam int          HOLD_BIT  = 2;
	localparam int          FORCE_BIT = 3;
	localparam int          SCI_BIT   = 5;
	localparam int          THR_LSB   = 8;
	localparam logic [31:0] CTRL_RST  = 32'h0000_07a0;
	localparam logic [7:0]  THR_LOW   = 8'hff;
	localparam logic [31:0] PN_GUARD  = 32'h0000_fff0;

	// ==========================================================
	// Security association select and interrupt bits
	localparam int IRQ_W         = 2;
	localparam int IRQ_EXH_BIT   = 0;
	localparam int IRQ_GUARD_BIT = 1;
	localparam int SA_SEL_BIT    = 0;
	localparam int SA_ACT_BIT    = 1;

	typedef enum logic [1:0] {
		MCSR_MODE_OFF  = 2'b00,
		MCSR_MODE_AUTH = 2'b01,
		MCSR_MODE_ENC  = 2'b10,
		MCSR_MODE_RSV  = 2'b11
	} mcsr_mode_t;

endpackage : mcsr_pkg

// ===== src/mcsr_regs.sv
/*
 * Capability and transmit-control register bank with key checksums,
 * packet-number tracking per security association and an interrupt.
 * Assumes a single-cycle register port and one frame request pulse per
 * transmitted frame from the transmit datapath.
 */

// Summary of operation
// - Both capability registers show one supported association group.
// - Transmit capability shows one secure channel, backed by two keys.
// - Receive capability shows the RX_SC channel count, with two keys per channel.
// - Transmit checksum is the XOR of every byte of both transmit keys.
// - Receive checksum is the bytewise XOR of all receive keys.
// - Mode field picks off, integrity only, or encrypt plus integrity.
// - With mode off, the untagged frame counter is never bumped.
// - The hold bit freezes the packet number for test use.
// - In either offload mode, the force bit protects every frame regardless of its descriptor.
// - The include bit, reset high, carries the channel id in each tag.
// - The threshold is control bits 31:8 above eight fixed one bits.
// - A packet number above the threshold raises the warning interrupt.
// - The active packet number grows by one per protected frame.
// - Sending the guard packet number forces the mode back to off.
module mcsr_regs #(
	parameter int RX_SC = 1
) (
	// Clock and reset
	input  wire logic                        i_clk,
	input  wire logic                        i_rst_n,
	// Register port
	input  wire logic [mcsr_pkg::ADDR_W-1:0] i_addr,
	input  wire logic [mcsr_pkg::DATA_W-1:0] i_wdata,
	input  wire logic                        i_wr,
	input  wire logic                        i_rd,
	output logic      [mcsr_pkg::DATA_W-1:0] o_rdata,
	// Transmit frame request
	input  wire logic                        i_tx_frame_valid,
	input  wire logic                        i_descriptor_protect_flag,
	// Transmit frame answer
	output logic                             o_tx_frame_done,
	output logic                             o_tx_frame_protect,
	output logic                             o_tx_frame_encrypt,
	output logic                             o_tx_frame_sci,
	output logic      [31:0]                 o_tx_frame_pn,
	output logic                             o_tx_untagged_inc,
	output logic      [1:0]                  o_tx_mode,
	// Interrupt
	output logic                             o_irq
);
	import mcsr_pkg::*;

	localparam int TXKW = TX_KEYS * KEY_WORDS;
	localparam int RXKW = 2 * RX_SC * KEY_WORDS;
	localparam logic [3:0]  RX_SC_NUM = 4'(RX_SC);
	localparam logic [15:0] TXK_SPAN  = 16'(TXKW * 4);
	localparam logic [15:0] RXK_SPAN  = 16'(RXKW * 4);

	typedef struct packed {
		logic [31:0]            ctrl;
		logic                   sel;
		logic                   act;
		logic [1:0][31:0]       pn;
		logic [TXKW-1:0][31:0]  tx_key;
		logic [RXKW-1:0][31:0]  rx_key;
		logic [IRQ_W-1:0]       stat;
		logic [IRQ_W-1:0]       mask;
		logic [31:0]            rdata;
		logic                   irq;
		logic                   done;
		logic                   prot;
		logic                   enc;
		logic                   sci;
		logic                   untag;
		logic [31:0]            fpn;
	} mcsr_state_t;

	mcsr_state_t q;
	mcsr_state_t d;

	// ==========================================================
	// Key checksums
	logic [TXKW:0][7:0] tx_part;
	logic [RXKW:0][7:0] rx_part;
	assign tx_part[0] = 8'h00;
	assign rx_part[0] = 8'h00;

	genvar gi;
	generate
		for (gi = 0; gi < TXKW; gi++) begin : g_txsum
			assign tx_part[gi+1] = tx_part[gi] ^ q.tx_key[gi][31:24]
				^ q.tx_key[gi][23:16] ^ q.tx_key[gi][15:8]
				^ q.tx_key[gi][7:0];
		end
		for (gi = 0; gi < RXKW; gi++) begin : g_rxsum
			assign rx_part[gi+1] = rx_part[gi] ^ q.rx_key[gi][31:24]
				^ q.rx_key[gi][23:16] ^ q.rx_key[gi][15:8]
				^ q.rx_key[gi][7:0];
		end
	endgenerate

	logic [7:0] tx_sum;
	logic [7:0] rx_sum;
	assign tx_sum = tx_part[TXKW];
	assign rx_sum = rx_part[RXKW];

	// ==========================================================
	// Address decode
	logic [15:0] tx_off;
	logic [15:0] rx_off;
	logic        tx_hit;
	logic        rx_hit;
	assign tx_off = i_addr - TX_KEY_OFS;
	assign rx_off = i_addr - RX_KEY_OFS;
	assign tx_hit = (tx_off < TXK_SPAN) && (i_addr[1:0] == 2'b00);
	assign rx_hit = (rx_off < RXK_SPAN) && (i_addr[1:0] == 2'b00);

	logic [31:0] act_pn;
	logic [31:0] thr;
	mcsr_mode_t  mode;
	assign act_pn = q.pn[q.act];
	assign thr  = {q.ctrl[31:THR_LSB], THR_LOW};
	assign mode = mcsr_mode_t'(q.ctrl[MODE_LSB+1:MODE_LSB]);

	// ==========================================================
	// Next state
	always_comb begin
		logic        offl;
		logic        prot;
		logic [1:0]  pn_wr;
		offl    = 1'b0;
		prot    = 1'b0;
		pn_wr   = 2'b00;
		d       = q;
		d.done  = 1'b0;
		d.prot  = 1'b0;
		d.enc   = 1'b0;
		d.untag = 1'b0;
		d.sci   = 1'b0;
		d.rdata = '0;

		// Software writes; capability words are not writable
		// read-only ignores writes
		if (i_wr) begin
			unique case (i_addr)
				TX_CTRL_OFS:  d.ctrl = i_wdata;
				TX_SA_OFS:    d.sel  = i_wdata[SA_SEL_BIT];
				TX_PN0_OFS: begin
					d.pn[0]  = i_wdata;
					pn_wr[0] = 1'b1;
				end
				TX_PN1_OFS: begin
					d.pn[1]  = i_wdata;
					pn_wr[1] = 1'b1;
				end
				IRQ_STAT_OFS: d.stat = q.stat & ~i_wdata[IRQ_W-1:0];
				IRQ_MASK_OFS: d.mask = i_wdata[IRQ_W-1:0];
				default: begin
					if (tx_hit) begin
						d.tx_key[tx_off[15:2]] = i_wdata;
					end
					if (rx_hit) begin
						d.rx_key[rx_off[15:2]] = i_wdata;
					end
				end
			endcase
		end

		// Frame handling; runs after writes so status sets win
		if (i_tx_frame_valid) begin
			offl   = (mode == MCSR_MODE_AUTH) || (mode == MCSR_MODE_ENC);
			prot   = offl && (i_descriptor_protect_flag
				|| q.ctrl[FORCE_BIT]);
			d.done = 1'b1;
			d.prot = prot;
			d.enc  = prot && (mode == MCSR_MODE_ENC);
			d.fpn  = act_pn;
			d.sci  = prot && q.ctrl[SCI_BIT];
			d.untag = offl && !prot;
			if (prot) begin
				if (!q.ctrl[HOLD_BIT] && !pn_wr[q.act]) begin
					d.pn[q.act] = act_pn + 32'h1;
				end
				if (act_pn > thr) begin
					d.stat[IRQ_EXH_BIT] = 1'b1;
				end
				if (act_pn == PN_GUARD) begin
					d.ctrl[MODE_LSB+1:MODE_LSB] = MCSR_MODE_OFF;
					d.stat[IRQ_GUARD_BIT] = 1'b1;
				end
			end
			// Key swap only on a frame boundary
			d.act = q.sel;
		end

		// Reads; unmapped and key words return zero
		if (i_rd) begin
			unique case (i_addr)
				TX_CAP_OFS: begin
					d.rdata[CA_LSB+:3]  = TX_CA_NUM;
					d.rdata[SC_LSB+:4]  = TX_SC_NUM;
					d.rdata[SUM_LSB+:8] = tx_sum;
				end
				RX_CAP_OFS: begin
					d.rdata[CA_LSB+:3]  = RX_CA_NUM;
					d.rdata[SC_LSB+:4]  = RX_SC_NUM;
					d.rdata[SUM_LSB+:8] = rx_sum;
				end
				TX_CTRL_OFS:  d.rdata = q.ctrl;
				TX_SA_OFS: begin
					d.rdata[SA_SEL_BIT] = q.sel;
					d.rdata[SA_ACT_BIT] = q.act;
				end
				TX_PN0_OFS:   d.rdata = q.pn[0];
				TX_PN1_OFS:   d.rdata = q.pn[1];
				IRQ_STAT_OFS: d.rdata[IRQ_W-1:0] = q.stat;
				IRQ_MASK_OFS: d.rdata[IRQ_W-1:0] = q.mask;
				default:      d.rdata = '0;
			endcase
		end

		// Level interrupt from unmasked sticky bits
		d.irq = |(d.stat & d.mask);
	end

	// ==========================================================
	// State register
	always_ff @(posedge i_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			q      <= '0;
			q.ctrl <= CTRL_RST;
		end else begin
			q <= d;
		end
	end

	assign o_rdata            = q.rdata;
	assign o_tx_frame_done    = q.done;
	assign o_tx_frame_protect = q.prot;
	assign o_tx_frame_encrypt = q.enc;
	assign o_tx_frame_sci     = q.sci;
	assign o_tx_frame_pn      = q.fpn;
	assign o_tx_untagged_inc  = q.untag;
	assign o_tx_mode          = q.ctrl[MODE_LSB+1:MODE_LSB];
	assign o_irq              = q.irq;

	// ==========================================================
	// Checks
	AST_TX_CAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == TX_CAP_OFS |=> o_rdata[6:0] == 7'h09
		&& o_rdata[23:16] == $past(tx_sum) && o_rdata[15:7] == 9'h0)
		else $error("transmit capability word wrong");

	AST_RX_CAP: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr == RX_CAP_OFS |=> o_rdata[2:0] == 3'h1
		&& o_rdata[23:16] == $past(rx_sum) && o_rdata[31:24] == 8'h0)
		else $error("receive capability word wrong");

	AST_UNTAG: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && o_tx_mode == 2'b00 |=> o_tx_frame_done
		&& !o_tx_untagged_inc && !o_tx_frame_protect)
		else $error("untagged count while offload off");

	AST_HOLD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && q.ctrl[HOLD_BIT] && !i_wr
		|=> q.pn == $past(q.pn))
		else $error("packet number moved while held");

	AST_FORCE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && q.ctrl[FORCE_BIT] && o_tx_mode == 2'b01
		|=> o_tx_frame_protect && !o_tx_untagged_inc)
		else $error("forced protection not applied");

	AST_EXH: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && (o_tx_mode == 2'b01 || o_tx_mode == 2'b10)
		&& (i_descriptor_protect_flag || q.ctrl[FORCE_BIT])
		&& act_pn > {q.ctrl[31:8], 8'hff} |=> q.stat[IRQ_EXH_BIT])
		else $error("exhaustion status not raised");

	AST_INC: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && !i_wr && !q.ctrl[HOLD_BIT]
		&& o_tx_mode == 2'b10 && i_descriptor_protect_flag
		|=> q.pn[$past(q.act)] == $past(act_pn) + 32'h1
		&& o_tx_frame_pn == $past(act_pn))
		else $error("packet number did not step by one");

	AST_GUARD: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && act_pn == PN_GUARD && o_tx_mode == 2'b01
		&& (i_descriptor_protect_flag || q.ctrl[FORCE_BIT])
		|=> o_tx_mode == 2'b00 && q.stat[IRQ_GUARD_BIT])
		else $error("offload not shut at guard number");

	AST_UNMAPPED: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_rd && i_addr[15:8] == 8'hb1 |=> o_rdata == 32'h0)
		else $error("unmapped read not zero");

	AST_STAT: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_tx_frame_valid |=> !$rose(q.stat[IRQ_EXH_BIT])
		&& !$rose(q.stat[IRQ_GUARD_BIT]))
		else $error("status bit set without a frame");

	AST_IRQ: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		|(q.stat & q.mask) && !(i_wr && (i_addr == IRQ_STAT_OFS
		|| i_addr == IRQ_MASK_OFS)) |=> o_irq)
		else $error("unmasked status without interrupt");

	AST_IRQ_LOW: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!(|(q.stat & q.mask)) && !i_tx_frame_valid
		&& !(i_wr && i_addr == IRQ_MASK_OFS) |=> !o_irq)
		else $error("interrupt without unmasked status");

	AST_MODE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && i_descriptor_protect_flag
		|=> o_tx_frame_encrypt == ($past(o_tx_mode) == 2'b10)
		&& o_tx_frame_protect == ($past(o_tx_mode) != 2'b00
		&& $past(o_tx_mode) != 2'b11))
		else $error("offload mode decoded wrongly");

	AST_SCI: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_tx_frame_valid && o_tx_mode == 2'b10 && i_descriptor_protect_flag
		|=> o_tx_frame_sci == $past(q.ctrl[SCI_BIT]))
		else $error("channel id inclusion wrong");

	AST_IDLE: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		!i_tx_frame_valid |=> !o_tx_frame_done && !o_tx_frame_protect
		&& !o_tx_untagged_inc && !o_tx_frame_sci)
		else $error("frame answer without a frame");

	AST_RO: assert property (@(posedge i_clk) disable iff (!i_rst_n)
		i_wr && (i_addr == TX_CAP_OFS || i_addr == RX_CAP_OFS)
		&& !i_tx_frame_valid |=> $stable(q.tx_key) && $stable(q.rx_key)
		&& $stable(q.ctrl) && $stable(q.mask))
		else $error("write to capability word changed state");

endmodule // mcsr_regs

// ===== dv/tb_mcsr_regs.sv
/*
 * Self-checking bench for the capability and transmit-control bank.
 * Assumes mcsr_pkg and mcsr_regs are compiled first; one 250 MHz clock.
 */
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin err_total++; \
	$display("[ERR] t=%0t got=%h exp=%h", $time, (g), (e)); end end

module tb_mcsr_regs;
	timeunit 1ns;
	timeprecision 1ps;
	import mcsr_pkg::*;

	// ==========================================================
	// Signals
	localparam int RXSC = 1;
	logic        clk;
	logic        rst_n;
	logic        wr;
	logic        rd;
	logic        fv;
	logic        flag;
	logic        done;
	logic        prot;
	logic        enc;
	logic        sci;
	logic        untag;
	logic        irq;
	logic [1:0]  mode;
	logic [15:0] addr;
	logic [31:0] wdata;
	logic [31:0] rdata;
	logic [31:0] f_pn;
	logic [31:0] seed;
	logic [31:0] ctrl;
	logic [31:0] pn0;
	logic [31:0] rv;
	logic [7:0]  s;
	int          err_total;
	int          checked;

	always #2 clk = ~clk;

	mcsr_regs #(.RX_SC(RXSC)) dut (
		.i_clk(clk), .i_rst_n(rst_n), .i_addr(addr), .i_wdata(wdata),
		.i_wr(wr), .i_rd(rd), .o_rdata(rdata), .i_tx_frame_valid(fv),
		.i_descriptor_protect_flag(flag), .o_tx_frame_done(done),
		.o_tx_frame_protect(prot), .o_tx_frame_encrypt(enc),
		.o_tx_frame_sci(sci), .o_tx_frame_pn(f_pn),
		.o_tx_untagged_inc(untag), .o_tx_mode(mode), .o_irq(irq));

	// ==========================================================
	// Helpers
	function automatic logic [31:0] rnd();
		seed = {seed[30:0], 1'b0} ^ (seed[31] ? 32'h0040_0007 : 32'h0);
		return seed;
	endfunction

	function automatic logic [31:0] cap(input logic [3:0] sc,
		input logic [7:0] sm);
		return {8'h00, sm, 9'h000, sc, 3'h1};
	endfunction

	function automatic logic [7:0] bx(input logic [31:0] d);
		return d[7:0] ^ d[15:8] ^ d[23:16] ^ d[31:24];
	endfunction

	task automatic wr32(input logic [15:0] a, input logic [31:0] d);
		@(posedge clk);
		wr <= 1'b1;
		addr <= a;
		wdata <= d;
		@(posedge clk);
		wr <= 1'b0;
	endtask

	task automatic chk_rd(input logic [15:0] a, input logic [31:0] e);
		@(posedge clk);
		rd <= 1'b1;
		addr <= a;
		@(posedge clk);
		rd <= 1'b0;
		#1;
		`CHK(rdata, e)
	endtask

	task automatic frame(input logic f);
		logic on;
		logic p;
		on = (ctrl[1:0] == 2'b01) || (ctrl[1:0] == 2'b10);
		p = on && (f || ctrl[FORCE_BIT]);
		@(posedge clk);
		fv <= 1'b1;
		flag <= f;
		@(posedge clk);
		fv <= 1'b0;
		#1;
		`CHK(done, 1'b1)
		`CHK(prot, p)
		`CHK(enc, p && ctrl[1:0] == 2'b10)
		`CHK(sci, p && ctrl[SCI_BIT])
		`CHK(untag, on && !p)
		`CHK(f_pn, pn0)
		if (p && pn0 == PN_GUARD) begin
			ctrl[1:0] = 2'b00;
		end
		if (p && !ctrl[HOLD_BIT]) begin
			pn0++;
		end
	endtask

	task automatic results();
		$display("checked=%0d err_total=%0d", checked, err_total);
		if (err_total == 0 && checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask

	// ==========================================================
	// Watchdog
	initial begin
		repeat (20000) @(posedge clk);
		err_total++;
		results();
	end

	// ==========================================================
	// Main sequence
	initial begin
		clk = 0;
		rst_n = 0;
		{wr, rd, fv, flag, addr, wdata} = '0;
		seed = 32'h429d5b94;
		ctrl = CTRL_RST;
		pn0 = 0;
		err_total = 0;
		checked = 0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		chk_rd(TX_CAP_OFS, cap(TX_SC_NUM, 8'h00));
		chk_rd(RX_CAP_OFS, cap(4'(RXSC), 8'h00));
		chk_rd(TX_CTRL_OFS, CTRL_RST);
		$display("test reset done");
		wr32(TX_CAP_OFS, 32'hffff_ffff);
		wr32(RX_CAP_OFS, 32'hffff_ffff);
		chk_rd(TX_CAP_OFS, cap(TX_SC_NUM, 8'h00));
		chk_rd(RX_CAP_OFS, cap(4'(RXSC), 8'h00));
		chk_rd(16'hb100, 32'h0);
		$display("test read_only done");
		s = 0;
		for (int i = 0; i < TX_KEYS * KEY_WORDS; i++) begin
			rv = rnd();
			s ^= bx(rv);
			wr32(TX_KEY_OFS + 16'(4 * i), rv);
		end
		chk_rd(TX_CAP_OFS, cap(TX_SC_NUM, s));
		s = 0;
		for (int i = 0; i < 2 * RXSC * KEY_WORDS; i++) begin
			rv = rnd();
			s ^= bx(rv);
			wr32(RX_KEY_OFS + 16'(4 * i), rv);
		end
		chk_rd(RX_CAP_OFS, cap(4'(RXSC), s));
		$display("test checksum done");
		// First half walks every mode, hold, force and include setting
		for (int i = 0; i < 64; i++) begin
			rv = rnd();
			ctrl = 32'h780 | (i < 32 ? {i[4], 1'b0, i[3:0]} : rv[13:8] & 6'h2f);
			wr32(TX_CTRL_OFS, ctrl);
			chk_rd(TX_CTRL_OFS, ctrl);
			`CHK(mode, ctrl[1:0])
			frame(rv[0]);
		end
		chk_rd(TX_PN0_OFS, pn0);
		$display("test frames done");
		ctrl = 32'h701;
		wr32(TX_CTRL_OFS, ctrl);
		wr32(IRQ_MASK_OFS, 32'h0);
		pn0 = 32'h7ff;
		wr32(TX_PN0_OFS, pn0);
		frame(1'b1);
		chk_rd(IRQ_STAT_OFS, 32'h0);
		frame(1'b1);
		chk_rd(IRQ_STAT_OFS, 32'h1);
		`CHK(irq, 1'b0)
		wr32(IRQ_MASK_OFS, 32'h1);
		repeat (2) @(posedge clk);
		#1;
		`CHK(irq, 1'b1)
		wr32(IRQ_STAT_OFS, 32'h1);
		repeat (2) @(posedge clk);
		#1;
		`CHK(irq, 1'b0)
		$display("test exhaust done");
		pn0 = PN_GUARD;
		wr32(TX_PN0_OFS, pn0);
		frame(1'b1);
		chk_rd(TX_CTRL_OFS, ctrl);
		`CHK(mode, 2'b00)
		chk_rd(IRQ_STAT_OFS, 32'h3);
		frame(1'b1);
		$display("test guard done");
		results();
	end
endmodule // tb_mcsr_regs
